// File: input_cond_pkg.sv
package input_cond_pkg;

	// ======================================================================
	// Clock and timing.
	// ======================================================================
	localparam int CLK_PERIOD_NS = 50;
	localparam int FILT_STEP_NS  = 1000000;
	localparam int FAST_FILT_NS  = 10000;
	localparam int MID_FILT_NS   = 50000;
	localparam int SLOW_FILT_NS  = 200000;
	// Least times, so each count rounds up to whole cycles.
	localparam int FILT_STEP_CYC =
		(FILT_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int FAST_FILT_CYC =
		(FAST_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int MID_FILT_CYC  =
		(MID_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SLOW_FILT_CYC =
		(SLOW_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ======================================================================
	// Input layout.
	// ======================================================================
	localparam int NUM_INPUTS     = 16;
	localparam int NUM_IRQ_INPUTS = 6;
	localparam int FAST_GROUP_END = 2;
	localparam int MID_GROUP_END  = 8;
	localparam int FILT_CNT_W     = 19;
	localparam int FILT_MAX_MS    = 15;

	// ======================================================================
	// Register map, byte addresses.
	// ======================================================================
	localparam logic [7:0] FILTER_TIME_OFFS = 8'h00;
	localparam logic [7:0] INPUT_STATE_OFFS = 8'h04;
	localparam logic [7:0] RUN_SELECT_OFFS  = 8'h08;
	localparam logic [7:0] IRQ_DISABLE_OFFS = 8'h0C;
	localparam logic [7:0] IRQ_STATUS_OFFS  = 8'h10;
	localparam logic [7:0] IRQ_MASK_OFFS    = 8'h14;

	// Reset values.
	localparam logic [3:0]  FILTER_TIME_RST = 4'hA;
	localparam logic [3:0]  RUN_SELECT_RST  = 4'h0;
	localparam logic [5:0]  IRQ_DISABLE_RST = 6'h00;
	localparam logic [11:0] IRQ_MASK_RST    = 12'h000;

	// Status layout: rising edges in the low field, falling above.
	localparam int RISE_LSB = 0;
	localparam int FALL_LSB = 6;

	// APB request from the master.
	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} apb_req_t;

	// APB answer to the master.
	typedef struct packed {
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} apb_rsp_t;

endpackage

// File: input_debounce.sv
`timescale 1ns/10ps
// ==========================================================================
// Digital filter for one discrete input.
// ==========================================================================
module input_debounce
	import input_cond_pkg::*;
#(
	parameter int CNT_W = FILT_CNT_W
) (
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	input  wire logic             raw_i,
	input  wire logic [CNT_W-1:0] limit_i,
	output logic                  state_o
);

	logic [CNT_W-1:0] cnt_q;

	// A new level is taken only after it has stood for limit_i cycles; any
	// bounce back to the old level restarts the count from zero.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cnt_q   <= '0;
			state_o <= 1'b0;
		end else if (raw_i == state_o) begin
			cnt_q <= '0;
		end else if (cnt_q >= limit_i - CNT_W'(1)) begin
			cnt_q   <= '0;
			state_o <= raw_i;
		end else begin
			cnt_q <= cnt_q + CNT_W'(1);
		end
	end

endmodule

// File: input_cond.sv
// Behaviour
// - An input reads on while its contact is closed, and its lamp lights then.
// - Any fitted input from the first to the highest may be the run input.
// - The first sixteen inputs are filtered for 1 to 15 ms in 1 ms steps.
// - A zero setting gives 10 us, 50 us and 200 us to the three groups.
// - The six lowest inputs can each raise a program interrupt.
// - Each interrupt input has two edge vectors and one disable flag.
`timescale 1ns/10ps
module input_cond
	import input_cond_pkg::*;
#(
	parameter int FILT_STEP_CYCLES = FILT_STEP_CYC,
	parameter int NUM_PRESENT      = NUM_INPUTS
) (
	input  wire logic                  clk_i,
	input  wire logic                  rst_i,
	input  wire input_cond_pkg::apb_req_t apb_i,
	output input_cond_pkg::apb_rsp_t   apb_o,
	input  wire logic [NUM_INPUTS-1:0] contact_closed_i,
	output logic      [NUM_INPUTS-1:0] input_lamp_o,
	output logic                       run_input_o,
	output logic                       irq_o
);
	import input_cond_pkg::*;

	localparam int N = NUM_INPUTS;
	localparam int M = NUM_IRQ_INPUTS;
	localparam int W = FILT_CNT_W;

	logic [N-1:0]   sync1_q;
	logic [N-1:0]   sync2_q;
	logic [N-1:0]   filtered;
	logic [N-1:0]   filt_lim_sel;
	logic [3:0]     input_filter_time_setting_q;
	logic [3:0]     run_sel_q;
	logic [M-1:0]   edge_irq_disable_q;
	logic [2*M-1:0] irq_status_q;
	logic [2*M-1:0] irq_status_d;
	logic [2*M-1:0] irq_mask_q;
	logic [M-1:0]   prev_q;
	logic [2*M-1:0] edge_set;
	logic           acc;
	logic           wr;
	logic           rd;
	logic           mapped;
	logic [31:0]    rdata;

	// ======================================================================
	// Filter limit per input.
	// ======================================================================
	// The group times apply only when the setting is zero; otherwise every
	// input uses the same millisecond count.
	function automatic logic [W-1:0] limit_for(input int idx,
		input logic [3:0] setting);
		logic [W-1:0] lim;
		lim = W'(32'(setting) * FILT_STEP_CYCLES);
		if (setting == 4'h0) begin
			if (idx < FAST_GROUP_END) begin
				lim = W'(FAST_FILT_CYC);
			end else if (idx < MID_GROUP_END) begin
				lim = W'(MID_FILT_CYC);
			end else begin
				lim = W'(SLOW_FILT_CYC);
			end
		end
		return lim;
	endfunction

	// ======================================================================
	// Pin synchronisers.
	// ======================================================================
	// A closed contact arrives as a high level; the pins are asynchronous.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			sync1_q <= '0;
			sync2_q <= '0;
		end else begin
			sync1_q <= contact_closed_i;
			sync2_q <= sync1_q;
		end
	end

	// ======================================================================
	// Filters.
	// ======================================================================
	genvar gi;
	generate
		for (gi = 0; gi < N; gi++) begin : g_filt
			input_debounce #(
				.CNT_W (W)
			) u_filt (
				.clk_i   (clk_i),
				.rst_i   (rst_i),
				.raw_i   (sync2_q[gi]),
				.limit_i (limit_for(gi, input_filter_time_setting_q)),
				.state_o (filtered[gi])
			);
		end
	endgenerate

	// Lamps follow the filtered on state of each input.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			input_lamp_o <= '0;
		end else begin
			input_lamp_o <= filtered;
		end
	end

	// A selection above the fitted inputs yields no run request rather than
	// a stale or floating one.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			run_input_o <= 1'b0;
		end else if (32'(run_sel_q) < NUM_PRESENT) begin
			run_input_o <= filtered[run_sel_q];
		end else begin
			run_input_o <= 1'b0;
		end
	end

	// ======================================================================
	// Edge interrupts.
	// ======================================================================
	// Edges are taken after the filter, so a pulse shorter than the zero
	// setting group time may be missed; the source must hold each level.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			prev_q <= '0;
		end else begin
			prev_q <= filtered[M-1:0];
		end
	end

	// A set disable flag masks both edges of its input at the source.
	always_comb begin
		edge_set = '0;
		for (int i = 0; i < M; i++) begin
			edge_set[RISE_LSB + i] = filtered[i] & ~prev_q[i] &
				~edge_irq_disable_q[i];
			edge_set[FALL_LSB + i] = ~filtered[i] & prev_q[i] &
				~edge_irq_disable_q[i];
		end
	end

	// A read of the status clears it, but an edge in that cycle still sets.
	always_comb begin
		irq_status_d = irq_status_q;
		if (rd && apb_i.paddr == IRQ_STATUS_OFFS) begin
			irq_status_d = '0;
		end
		irq_status_d = irq_status_d | edge_set;
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			irq_status_q <= '0;
		end else begin
			irq_status_q <= irq_status_d;
		end
	end

	assign irq_o = |(irq_status_q & irq_mask_q);

	// ======================================================================
	// APB slave.
	// ======================================================================
	// Zero wait states: every access completes in its first access cycle.
	assign acc = apb_i.psel & apb_i.penable;
	assign wr  = acc & apb_i.pwrite;
	assign rd  = acc & ~apb_i.pwrite;

	// Control registers written by software.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			input_filter_time_setting_q <= FILTER_TIME_RST;
			run_sel_q                   <= RUN_SELECT_RST;
			edge_irq_disable_q          <= IRQ_DISABLE_RST;
			irq_mask_q                  <= IRQ_MASK_RST;
		end else if (wr) begin
			if (apb_i.paddr == FILTER_TIME_OFFS) begin
				input_filter_time_setting_q <= apb_i.pwdata[3:0];
			end else if (apb_i.paddr == RUN_SELECT_OFFS) begin
				run_sel_q <= apb_i.pwdata[3:0];
			end else if (apb_i.paddr == IRQ_DISABLE_OFFS) begin
				edge_irq_disable_q <= apb_i.pwdata[M-1:0];
			end else if (apb_i.paddr == IRQ_MASK_OFFS) begin
				irq_mask_q <= apb_i.pwdata[2*M-1:0];
			end
		end
	end

	// Read multiplexer and address check; unused bits read as zero.
	always_comb begin
		rdata  = 32'h0000_0000;
		mapped = 1'b1;
		if (apb_i.paddr == FILTER_TIME_OFFS) begin
			rdata[3:0] = input_filter_time_setting_q;
		end else if (apb_i.paddr == INPUT_STATE_OFFS) begin
			rdata[N-1:0] = filtered;
		end else if (apb_i.paddr == RUN_SELECT_OFFS) begin
			rdata[3:0] = run_sel_q;
		end else if (apb_i.paddr == IRQ_DISABLE_OFFS) begin
			rdata[M-1:0] = edge_irq_disable_q;
		end else if (apb_i.paddr == IRQ_STATUS_OFFS) begin
			rdata[2*M-1:0] = irq_status_q;
		end else if (apb_i.paddr == IRQ_MASK_OFFS) begin
			rdata[2*M-1:0] = irq_mask_q;
		end else begin
			mapped = 1'b0;
		end
	end

	assign apb_o.pready  = 1'b1;
	assign apb_o.pslverr = acc & ~mapped;
	assign apb_o.prdata  = rd ? rdata : 32'h0000_0000;

	// Note: run selections at or beyond NUM_PRESENT give no run request; inputs used by
	// other functions are left to configuration; nothing here arbitrates between them.

endmodule

// File: contact_bank.sv
`timescale 1ns/10ps
// ======
// Field contacts on the far side of the input pins.
// ======
module contact_bank (
	input  wire logic [15:0] want_i,
	input  wire logic [15:0] chatter_i,
	output logic      [15:0] contact_o
);
	// Each pin may serve as a plain or run input, the six lowest also as interrupt
	// inputs, and a bench command flips it while chatter is set, like a bouncing contact.
	assign contact_o = want_i ^ chatter_i;
endmodule

// File: input_cond_sva.sv
`timescale 1ns/10ps
// ======
// Checker on the block's pins.
// ======
module input_cond_sva (
	input wire logic                     clk_i,
	input wire logic                     rst_i,
	input wire input_cond_pkg::apb_req_t apb_i,
	input wire input_cond_pkg::apb_rsp_t apb_o,
	input wire logic [15:0]              contact_closed_i,
	input wire logic [15:0]              input_lamp_o,
	input wire logic                     run_input_o,
	input wire logic                     irq_o
);
	import input_cond_pkg::*;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic acc;
	logic hit;
	// Access phase, and whether it lands on a mapped aligned word.
	assign acc = apb_i.psel & apb_i.penable;
	assign hit = apb_i.paddr <= IRQ_MASK_OFFS && apb_i.paddr[1:0] == 2'h0;
	ready_always_a: assert property (apb_o.pready)
		else $error("pready low");
	map_error_a: assert property (acc |-> apb_o.pslverr == !hit)
		else $error("pslverr wrong");
	idle_rdata_a: assert property (!(acc && !apb_i.pwrite) |->
		apb_o.prdata == 32'h0) else $error("prdata not zero");
	reset_quiet_a: assert property (disable iff (1'b0) rst_i |->
		input_lamp_o == 16'h0 && !irq_o && !run_input_o)
		else $error("outputs active in reset");
	// Two sync flops, the filter flop and the lamp flop put the lamp four
	// samples behind the pin.
	lamp_follow_a: assert property (((input_lamp_o ^ $past(input_lamp_o))
		& (input_lamp_o ^ $past(contact_closed_i, 4))) == 16'h0)
		else $error("lamp moved against pin");
	glitch_reject_a: assert property (((input_lamp_o ^ $past(input_lamp_o))
		& ($past(contact_closed_i, 4) ^ $past(contact_closed_i, 8)))
		== 16'h0) else $error("lamp took short pulse");
	irq_cause_a: assert property ($rose(irq_o) |->
		input_lamp_o[5:0] != $past(input_lamp_o[5:0]) || $past(acc &&
		apb_i.pwrite && apb_i.paddr == IRQ_MASK_OFFS))
		else $error("irq rose without cause");
	irq_drop_a: assert property ($fell(irq_o) |-> $past(acc &&
		apb_i.paddr == (apb_i.pwrite ? IRQ_MASK_OFFS : IRQ_STATUS_OFFS)))
		else $error("irq fell without cause");
	cover property ($rose(irq_o));
	cover property (acc && apb_o.pslverr);
	cover property ($changed(input_lamp_o));
endmodule
bind input_cond input_cond_sva i_sva (.*);

// File: testbench.sv
`timescale 1ns/10ps
// ======
// Self-checking bench for the input block.
// ======
module testbench;
	import input_cond_pkg::*;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b0;
	apb_req_t    req = '0;
	apb_rsp_t    rsp;
	logic [15:0] want = 16'h0, chat = 16'h0, pins, lamp, old;
	logic        run, irq, er, exp_run;
	logic [31:0] rd;
	logic [11:0] st = 12'h0, msk;
	logic [5:0]  dis = 6'h0;
	int          err_count = 0, tests_run = 0, fs;
	// Clock of 50 ns period.
	always #25 clk_i = ~clk_i;
	contact_bank i_bank (.want_i(want), .chatter_i(chat), .contact_o(pins));
	// One millisecond shrinks to 20 cycles to keep the run short; twelve
	// fitted inputs leave four run selections that must read off.
	localparam int FITTED = 12;
	input_cond #(.FILT_STEP_CYCLES(20), .NUM_PRESENT(FITTED)) i_dut (
		.clk_i(clk_i), .rst_i(rst_i),
		.apb_i(req), .apb_o(rsp), .contact_closed_i(pins),
		.input_lamp_o(lamp), .run_input_o(run), .irq_o(irq));
	task conclude;
		if (err_count == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// Register bus results: read data and error flags.
	task chk_reg(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			err_count++;
			$display("MISMATCH %s exp %h got %h", nm, e, g);
		end
	endtask
	// Pin results: lamps, run input and interrupt line.
	task chk_pin(input string nm, input logic [15:0] e,
		input logic [15:0] g);
		tests_run++;
		if (g !== e) begin
			err_count++;
			$display("MISMATCH %s exp %h got %h", nm, e, g);
		end
	endtask
	// The request stands until pready is seen high at an edge.
	// Only the watchdog ends a wait for pready.
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		req <= '{1'b1, 1'b0, w, a, d};
		@(posedge clk_i);
		req.penable <= 1'b1;
		do begin
			@(posedge clk_i);
		end while (rsp.pready !== 1'b1);
		rd = rsp.prdata;
		er = rsp.pslverr;
		req <= '0;
	endtask
	// Moves the contacts and notes which edges should latch.
	task step(input logic [15:0] nw);
		st = st | {want[5:0] & ~nw[5:0] & ~dis, ~want[5:0] & nw[5:0] & ~dis};
		old = want;
		want <= nw;
	endtask
	task wt(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	// Cuts a hang short after 40000 cycles.
	initial begin
		#2000000;
		err_count++;
		conclude;
	end
	// Main sequence.
	initial begin
		// Reset rises at time zero through a non-blocking write so that the flops see its edge.
		rst_i <= 1'b1;
		void'($urandom(32'h975E));
		wt(6);
		rst_i <= 1'b0;
		for (int i = 0; i < 7; i++) begin
			apb(1'b0, 8'(i * 4), 32'h0);
			chk_reg("rdata", (i == 0) ? 32'hA : 32'h0, rd);
			chk_reg("slverr", 32'(i == 6), 32'(er));
		end
		for (int k = 0; k < 8; k++) begin
			fs = (k % 2) ? 15 : 1;
			dis = 6'($urandom);
			msk = 12'($urandom);
			apb(1'b1, FILTER_TIME_OFFS, fs);
			apb(1'b1, IRQ_DISABLE_OFFS, 32'(dis));
			apb(1'b1, IRQ_MASK_OFFS, 32'(msk));
			step(16'($urandom));
			wt(20 * fs - 10);
			chk_pin("lamp", old, lamp);
			wt(30);
			chk_pin("lamp", want, lamp);
			chk_pin("irq", 16'(|(st & msk)), 16'(irq));
			apb(1'b0, IRQ_STATUS_OFFS, 32'h0);
			chk_reg("status", 32'(st), rd);
			st = 12'h0;
			apb(1'b0, INPUT_STATE_OFFS, 32'h0);
			chk_pin("irq", 16'h0, 16'(irq));
			chk_reg("state", 32'(want), rd);
		end
		// A burst shorter than the filter must leave everything still.
		chat <= 16'($urandom);
		wt(10);
		chat <= 16'h0;
		wt(320);
		chk_pin("lamp", want, lamp);
		apb(1'b0, IRQ_STATUS_OFFS, 32'h0);
		chk_reg("status", 32'h0, rd);
		// Selections above the fitted inputs must give no run request.
		for (int s = 0; s < 16; s++) begin
			apb(1'b1, RUN_SELECT_OFFS, s);
			wt(3);
			exp_run = (s < FITTED) && want[s];
			chk_pin("run", 16'(exp_run), 16'(run));
		end
		// Zero setting: the three groups settle at 200, 1000, 4000.
		apb(1'b1, FILTER_TIME_OFFS, 32'h0);
		step(~want);
		wt(150);
		chk_pin("lamp", old, lamp);
		wt(100);
		chk_pin("lamp", old ^ 16'h0003, lamp);
		wt(800);
		chk_pin("lamp", old ^ 16'h00FF, lamp);
		wt(3000);
		chk_pin("lamp", want, lamp);
		apb(1'b0, IRQ_STATUS_OFFS, 32'h0);
		chk_reg("status", 32'(st), rd);
		conclude;
	end
endmodule
